/* File: src/sdl_master.sv */
// Master end: sends one 16-bit word per request and pulses the load strobe
`timescale 1ns/10ps
`default_nettype none
module sdl_master #(
  parameter int WORD_W = sdl_pkg::WORD_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Word request
  input wire logic req_valid,
  input wire logic [15:0] req_word,
  input wire logic req_use_strobe,
  output logic req_ready,
  output logic done,
  // Link
  sdl_link_if.master link
);
  sdl_pkg::sdl_state_t state_q;
  logic [15:0] sh_q;
  logic [sdl_pkg::CNT_W-1:0] bit_q;
  logic [sdl_pkg::TMR_W-1:0] tmr_q;
  logic strobe_q;
  logic cs_q, sclk_q, sdi_q, ldn_q, rdy_q, done_q;

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  // Data changes only while sclk is low, so the device samples stable bits.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= sdl_pkg::SDL_IDLE;
      sh_q <= 16'h0000;
      bit_q <= 5'h00;
      tmr_q <= 4'h0;
      strobe_q <= 1'b0;
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      sdi_q <= 1'b0;
      ldn_q <= 1'b1;
      rdy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        sdl_pkg::SDL_IDLE: begin
          rdy_q <= 1'b1;
          if (req_valid && rdy_q) begin
            rdy_q <= 1'b0;
            sh_q <= {req_word[14:0], 1'b0};
            sdi_q <= req_word[15];
            strobe_q <= req_use_strobe;
            cs_q <= 1'b0;
            bit_q <= 5'h00;
            tmr_q <= 4'(sdl_pkg::SCLK_HALF_CYC - 1);
            state_q <= sdl_pkg::SDL_LOW;
          end
        end
        sdl_pkg::SDL_LOW: begin
          if (tmr_q == 4'h0) begin
            sclk_q <= 1'b1;
            tmr_q <= 4'(sdl_pkg::SCLK_HALF_CYC - 1);
            bit_q <= bit_q + 5'h01;
            state_q <= sdl_pkg::SDL_HIGH;
          end else begin
            tmr_q <= tmr_q - 4'h1;
          end
        end
        sdl_pkg::SDL_HIGH: begin
          if (tmr_q == 4'h0) begin
            sclk_q <= 1'b0;
            tmr_q <= 4'(sdl_pkg::SCLK_HALF_CYC - 1);
            if (bit_q == 5'(WORD_W)) begin
              state_q <= sdl_pkg::SDL_LAG;
            end else begin
              sdi_q <= sh_q[15];
              sh_q <= {sh_q[14:0], 1'b0};
              state_q <= sdl_pkg::SDL_LOW;
            end
          end else begin
            tmr_q <= tmr_q - 4'h1;
          end
        end
        sdl_pkg::SDL_LAG: begin
          if (tmr_q == 4'h0) begin
            cs_q <= 1'b1;
            // Without a strobe the frame goes straight to the select-high gap
            if (strobe_q) begin
              tmr_q <= 4'(sdl_pkg::LOAD_DLY_CYC - 1);
            end else begin
              tmr_q <= 4'(sdl_pkg::CS_GAP_CYC - 1);
            end
            state_q <= strobe_q ? sdl_pkg::SDL_LDLY : sdl_pkg::SDL_LEAD;
          end else begin
            tmr_q <= tmr_q - 4'h1;
          end
        end
        sdl_pkg::SDL_LDLY: begin
          if (tmr_q == 4'h0) begin
            ldn_q <= 1'b0;
            tmr_q <= 4'(sdl_pkg::LOAD_W_CYC - 1);
            state_q <= sdl_pkg::SDL_LPULSE;
          end else begin
            tmr_q <= tmr_q - 4'h1;
          end
        end
        sdl_pkg::SDL_LPULSE: begin
          if (tmr_q == 4'h0) begin
            ldn_q <= 1'b1;
            tmr_q <= 4'(sdl_pkg::CS_GAP_CYC - 1);
            state_q <= sdl_pkg::SDL_LEAD;
          end else begin
            tmr_q <= tmr_q - 4'h1;
          end
        end
        sdl_pkg::SDL_LEAD: begin
          // Guarantees the minimum select-high gap before the next frame
          if (tmr_q == 4'h0) begin
            done_q <= 1'b1;
            state_q <= sdl_pkg::SDL_IDLE;
          end else begin
            tmr_q <= tmr_q - 4'h1;
          end
        end
        default: begin
          state_q <= sdl_pkg::SDL_IDLE;
        end
      endcase
    end
  end

  assign link.cs_n = cs_q;
  assign link.sclk = sclk_q;
  assign link.sdi = sdi_q;
  assign link.latch_load_strobe_n = ldn_q;
  assign req_ready = rdy_q;
  assign done = done_q;
endmodule
`default_nettype wire

/* File: src/sdl_pkg.sv */
// Package with widths and constants shared by both ends of the serial word link
package sdl_pkg;
  // ---------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int SEG_MSB_W = 4;
  localparam int SEG_CNT = 15;
  localparam int LADDER_W = 12;
  localparam int CNT_W = 5;
  localparam logic [15:0] LATCH_RST = 16'h0000;
  localparam logic [15:0] INREG_RST = 16'h0000;
  // ---------------------------------------------------------------
  // Master timing, in ns and in cycles of the master clock
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCLK_HALF_NS = 20;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_GAP_NS = 30;
  localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_DLY_NS = 30;
  localparam int LOAD_DLY_CYC = (LOAD_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_W_NS = 30;
  localparam int LOAD_W_CYC = (LOAD_W_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 4;
  // ---------------------------------------------------------------
  // Master states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SDL_IDLE = 3'h0,
    SDL_LEAD = 3'h1,
    SDL_LOW = 3'h3,
    SDL_HIGH = 3'h2,
    SDL_LAG = 3'h6,
    SDL_LDLY = 3'h7,
    SDL_LPULSE = 3'h5
  } sdl_state_t;
endpackage

/* File: src/sdl_link_if.sv */
// Interface carrying the three-wire link and the load strobe
`timescale 1ns/10ps
`default_nettype none
interface sdl_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic latch_load_strobe_n;
  modport master (output cs_n, output sclk, output sdi, output latch_load_strobe_n);
  modport device (input cs_n, input sclk, input sdi, input latch_load_strobe_n);
endinterface
`default_nettype wire

/* File: src/sdl_seg_decode.sv */
// Thermometer decode of the top latch bits into segment switch controls
`timescale 1ns/10ps
`default_nettype none
module sdl_seg_decode (
  // Code in
  input wire logic [sdl_pkg::SEG_MSB_W-1:0] code,
  // Segment switches
  output logic [sdl_pkg::SEG_CNT-1:0] seg_on
);
  always_comb begin
    for (int i = 0; i < sdl_pkg::SEG_CNT; i++) begin
      seg_on[i] = (32'(code) > i);
    end
  end
endmodule
`default_nettype wire

/* File: src/sdl_device.sv */
// Device end: shift register, input register, latch and switch decode
// Behaviour
// - Words, shift, input and latch are 16 bits
// - Power-up clears input register and latch
// - Shift register has no power-up value
// - Master sends at least 16 bits first
// - Short frame keeps older shift bits
// - Master pads short data with LSB zeros
// - Chip select high ignores clock and data
// - Sample data on rising clock, MSB first
// - Master frames, clocks, changes data falling
// - Chip select rise copies shift to input
// - Master sends sixteen clocks then raises select
// - Extra clocks keep only last sixteen bits
// - Master holds select low whole frame
// - No-strobe variant updates latch with input
// - Strobe low after select updates latch
// - Master holds strobe high during frame
// - Strobe tied low: latch follows input load
// - Latch is straight binary code
// - Four MSBs to 15 segments, 12 ladder
// - Strobe low: latch follows input continuously
`timescale 1ns/10ps
`default_nettype none
module sdl_device #(
  parameter bit HAS_STROBE = 1'b1
) (
  // Power-on reset
  input wire logic resetn,
  // Link
  sdl_link_if.device link,
  // Converter switches
  output logic [sdl_pkg::WORD_W-1:0] latch_code,
  output logic [sdl_pkg::SEG_CNT-1:0] seg_on,
  output logic [sdl_pkg::LADDER_W-1:0] ladder_on
);
  logic [sdl_pkg::WORD_W-1:0] shift_q;
  logic [sdl_pkg::WORD_W-1:0] inreg_q;
  logic [sdl_pkg::WORD_W-1:0] latch_q;
  logic strobe_low;

  // ---------------------------------------------------------------
  // Shift register
  // ---------------------------------------------------------------
  // No reset: contents are unknown until shifted. Gated by select low.
  always_ff @(posedge link.sclk) begin
    if (!link.cs_n) begin
      shift_q <= {shift_q[sdl_pkg::WORD_W-2:0], link.sdi};
    end
  end

  // ---------------------------------------------------------------
  // Input register
  // ---------------------------------------------------------------
  // Select rising edge acts as a clock; the latch takes the new value only while strobe_low is set.
  always_ff @(posedge link.cs_n or negedge resetn) begin
    if (!resetn) begin
      inreg_q <= sdl_pkg::INREG_RST;
    end else begin
      inreg_q <= shift_q;
    end
  end

  // ---------------------------------------------------------------
  // Latch
  // ---------------------------------------------------------------
  assign strobe_low = HAS_STROBE ? !link.latch_load_strobe_n : 1'b1;

  // Transparent while strobe_low is set; modelled as a level latch.
  always_latch begin
    if (!resetn) begin
      latch_q <= sdl_pkg::LATCH_RST;
    end else if (strobe_low) begin
      latch_q <= inreg_q;
    end
  end

  // ---------------------------------------------------------------
  // Switch decode
  // ---------------------------------------------------------------
  assign latch_code = latch_q;
  assign ladder_on = latch_q[sdl_pkg::LADDER_W-1:0];

  sdl_seg_decode u_seg (
    .code(latch_q[sdl_pkg::WORD_W-1:sdl_pkg::LADDER_W]),
    .seg_on(seg_on)
  );
endmodule
`default_nettype wire

/* File: test/sdl_monitor.sv */
// Checker of the master's timing on the three-wire link
`timescale 1ns/10ps
`default_nettype none
module sdl_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic latch_load_strobe_n
);
  // --------
  // Frame timing
  // --------
  logic [4:0] nrise_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Counts link clock rises while selected, cleared whenever deselected
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      nrise_q <= 5'h00;
    end else if (cs_n) begin
      nrise_q <= 5'h00;
    end else begin
      nrise_q <= nrise_q + 5'($rose(sclk));
    end
  end
  a_strobe_high_frame: assert property (!cs_n |-> latch_load_strobe_n)
    else $error("strobe low while selected");
  a_data_while_low: assert property ($changed(sdi) |-> !sclk)
    else $error("data changed while link clock high");
  a_sixteen_clocks: assert property ($rose(cs_n) |-> nrise_q == 5'h10)
    else $error("frame did not carry sixteen clocks");
  a_frame_unbroken: assert property ($fell(sclk) |-> ##[1:2] (sclk || cs_n))
    else $error("frame stalled");
  a_sclk_high_one: assert property ($rose(sclk) |=> !sclk)
    else $error("link clock high too long");
  a_first_edge_lead: assert property ($fell(cs_n) |-> !sclk ##1 sclk)
    else $error("first clock not one cycle after select");
  a_select_gap: assert property ($rose(cs_n) |=> cs_n [*2])
    else $error("deselect gap too short");
  a_strobe_width: assert property ($fell(latch_load_strobe_n) |=>
    !latch_load_strobe_n ##1 latch_load_strobe_n)
    else $error("strobe width wrong");
  a_strobe_after_sel: assert property ($fell(latch_load_strobe_n) |->
    cs_n && $past(cs_n, 2))
    else $error("strobe too soon after deselect");
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench joining master and devices over the link
`timescale 1ns/10ps
`default_nettype none
module tb;
  // --------
  // Ends and link
  // --------
  logic clock;
  logic resetn;
  logic req_valid;
  logic [15:0] req_word;
  logic req_use_strobe;
  logic req_ready;
  logic done;
  logic [15:0] code_s, code_n, code_f;
  logic [14:0] seg_n;
  logic [11:0] lad_n;
  int miscompares;
  int checks_done;
  sdl_link_if link();
  sdl_link_if link2();
  sdl_master u_sdl_master (.clock(clock), .resetn(resetn), .req_valid(req_valid),
    .req_word(req_word), .req_use_strobe(req_use_strobe), .req_ready(req_ready),
    .done(done), .link(link));
  sdl_device u_sdl_device (.resetn(resetn), .link(link), .latch_code(code_s),
    .seg_on(), .ladder_on());
  sdl_device #(.HAS_STROBE(1'b0)) u_sdl_device_n (.resetn(resetn), .link(link),
    .latch_code(code_n), .seg_on(seg_n), .ladder_on(lad_n));
  sdl_device u_sdl_device_f (.resetn(resetn), .link(link2), .latch_code(code_f),
    .seg_on(), .ladder_on());
  sdl_monitor u_sdl_monitor (.clock(clock), .resetn(resetn), .cs_n(link.cs_n),
    .sclk(link.sclk), .sdi(link.sdi), .latch_load_strobe_n(link.latch_load_strobe_n));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic send(input logic [15:0] w, input logic s);
    int n;
    n = 0;
    @(negedge clock);
    req_valid = 1'b1;
    req_word = w;
    req_use_strobe = s;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    if (n >= 100) begin
      miscompares++;
      results();
    end
    @(negedge clock);
    req_valid = 1'b0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    if (n >= 200) begin
      miscompares++;
      results();
    end
  endtask
  // Bench-made frame on the second link; fr low keeps the device deselected
  task automatic shift(input logic [31:0] v, input int nb, input logic fr);
    link2.cs_n = !fr;
    for (int i = nb - 1; i >= 0; i--) begin
      link2.sdi = v[i];
      #15 link2.sclk = 1'b1;
      #15 link2.sclk = 1'b0;
    end
    #15 link2.cs_n = 1'b1;
    link2.sdi = !link2.sdi;
    #15;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req_word = 16'h0000;
    req_use_strobe = 1'b0;
    link2.cs_n = 1'b1;
    link2.sclk = 1'b0;
    link2.sdi = 1'b0;
    link2.latch_load_strobe_n = 1'b0;
    miscompares = 0;
    checks_done = 0;
    repeat (10) @(negedge clock);
    chk("latch_s", code_s, 16'h0000);
    chk("latch_n", code_n, 16'h0000);
    chk("latch_f", code_f, 16'h0000);
    resetn = 1'b1;
    $display("test reset done");
    send(16'hA5C3, 1'b0);
    chk("latch_s", code_s, 16'h0000);
    chk("latch_n", code_n, 16'hA5C3);
    send(16'h3C5A, 1'b1);
    chk("latch_s", code_s, 16'h3C5A);
    chk("latch_n", code_n, 16'h3C5A);
    send({12'hABC, 4'h0}, 1'b1);
    chk("latch_s", code_s, 16'hABC0);
    $display("test strobe done");
    for (int i = 0; i < 16; i++) begin
      send({4'(i), 12'(i * 273)}, 1'b1);
      chk("latch_n", code_n, {4'(i), 12'(i * 273)});
      chk("latch_s", code_s, {4'(i), 12'(i * 273)});
      chk("seg_on", {1'b0, seg_n}, 16'((1 << i) - 1));
      chk("ladder", {4'h0, lad_n}, 16'(i * 273));
    end
    $display("test codes done");
    shift(32'h0000_1234, 16, 1'b1);
    chk("latch_f", code_f, 16'h1234);
    shift(32'hFFFF_FFFF, 4, 1'b0);
    shift(32'h0000_00AB, 8, 1'b1);
    chk("latch_f", code_f, 16'h34AB);
    shift(32'h000F_BEEF, 20, 1'b1);
    chk("latch_f", code_f, 16'hBEEF);
    $display("test frames done");
    // Strobe held high across a frame, then lowered after select rises
    link2.latch_load_strobe_n = 1'b1;
    shift(32'h0000_5A5A, 16, 1'b1);
    chk("latch_f", code_f, 16'hBEEF);
    link2.latch_load_strobe_n = 1'b0;
    #15;
    chk("latch_f", code_f, 16'h5A5A);
    shift(32'h0000_0F0F, 16, 1'b1);
    chk("latch_f", code_f, 16'h0F0F);
    $display("test strobe level done");
    // Reset in mid-run clears loaded latches
    resetn = 1'b0;
    @(negedge clock);
    chk("latch_s", code_s, 16'h0000);
    chk("latch_n", code_n, 16'h0000);
    chk("latch_f", code_f, 16'h0000);
    resetn = 1'b1;
    send(16'h8001, 1'b1);
    chk("latch_s", code_s, 16'h8001);
    chk("latch_n", code_n, 16'h8001);
    $display("test restart done");
    results();
  end
endmodule
`default_nettype wire
